// ---- verilog/fldc_params.svh ----
`ifndef FLDC_PARAMS_SVH
`define FLDC_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FLDC_CLK_HZ        50000000
`define FLDC_MS_PER_S      1000
`define FLDC_DLY_D_MS      8'h00
`define FLDC_DLY_C_MS      8'h0B
`define FLDC_DLY_B_MS      8'h32
`define FLDC_DLY_A_MS      8'hAF

// ----------------------------------------
// Rate table: bps and switch patterns, bit 0 = switch 1, 1 = on
// ----------------------------------------
`define FLDC_RATE_DEF      4'h5
`define FLDC_BPS_0         2400
`define FLDC_BPS_1         4800
`define FLDC_BPS_2         9600
`define FLDC_BPS_3         19200
`define FLDC_BPS_4         38400
`define FLDC_BPS_5         56000
`define FLDC_BPS_6         64000
`define FLDC_BPS_7         112000
`define FLDC_BPS_8         128000
`define FLDC_BPS_9         256000
`define FLDC_SW_0          12'hFD9
`define FLDC_SW_1          12'hD97
`define FLDC_SW_2          12'hD93
`define FLDC_SW_3          12'hD91
`define FLDC_SW_4          12'hD90
`define FLDC_SW_5          12'hF50
`define FLDC_SW_6          12'hD50
`define FLDC_SW_7          12'hF20
`define FLDC_SW_8          12'hD20
`define FLDC_SW_9          12'h620

// ----------------------------------------
// Switch and jumper positions
// ----------------------------------------
`define FLDC_CSW_REC       0
`define FLDC_CSW_INT       1
`define FLDC_CSW_EXT       2
`define FLDC_JMP_A         0
`define FLDC_JMP_B         1
`define FLDC_JMP_C         2
`define FLDC_JMP_D         3
`define FLDC_JMP_E         4

// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define FLDC_OFF_CTRL      12'h000
`define FLDC_OFF_STAT      12'h004
`define FLDC_OFF_RATE      12'h008
`define FLDC_CTRL_RST      32'h00000000
`define FLDC_CTRL_OVR      0
`define FLDC_CTRL_RATE     4
`define FLDC_CTRL_SRC      8
`define FLDC_CTRL_CAR      12
`define FLDC_CTRL_HALF     16
`define FLDC_ST_RTS        8
`define FLDC_ST_CTS        9
`define FLDC_ST_CD         10
`define FLDC_ST_TXEN       11

`endif

// ---- verilog/fldc_pkg.sv ----
package fldc_pkg;

  typedef enum logic [1:0] {FLDC_SRC_INT, FLDC_SRC_REC, FLDC_SRC_EXT} fldc_src_e;

  typedef enum logic [2:0] {FLDC_CAR_CONST, FLDC_CAR_D, FLDC_CAR_C, FLDC_CAR_B, FLDC_CAR_A} fldc_car_e;

  typedef enum logic [1:0] {FLDC_CTS_IDLE, FLDC_CTS_WAIT, FLDC_CTS_CLEAR} fldc_cts_e;

  typedef struct packed {
    logic [3:0] rate;
    fldc_src_e  src;
    fldc_car_e  car;
    logic       half;
  } fldc_cfg_s;

  typedef struct packed {
    logic [3:0]  rate_lo;
    logic [7:0]  rate_hi;
    logic [3:0]  clk_sw;
    logic [4:0]  jumper;
    logic        half;
    logic        rts;
    logic        td;
    logic        etc;
    logic        rx_clk;
    logic        rx_data;
    logic        rx_car;
  } fldc_pins_s;

endpackage : fldc_pkg

// ---- verilog/fldc_delay_timer.sv ----
`timescale 1ns/1ps
`include "fldc_params.svh"

module fldc_delay_timer
  import fldc_pkg::*;
#(
  parameter int MS_CYCLES = `FLDC_CLK_HZ / `FLDC_MS_PER_S
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       restart,
  input  wire logic [7:0] delay_ms,
  output logic            done
);

  localparam int TW = $clog2(MS_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);

  logic [TW-1:0] tick_cnt_r;
  logic [7:0]    ms_cnt_r;

  // ----------------------------------------
  // Millisecond tick and count, restarted on request
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || restart) begin
      tick_cnt_r <= '0;
      ms_cnt_r   <= 8'h00;
    end else if (ms_cnt_r < delay_ms) begin
      if (tick_cnt_r == TICK_LAST) begin
        tick_cnt_r <= '0;
        ms_cnt_r   <= ms_cnt_r + 8'h01;
      end else begin
        tick_cnt_r <= tick_cnt_r + TW'(1);
      end
    end
  end

  assign done = (ms_cnt_r >= delay_ms);

endmodule : fldc_delay_timer

// ---- verilog/fldc_top.sv ----
`timescale 1ns/1ps
`include "fldc_params.svh"

module fldc_top
  import fldc_pkg::*;
#(
  parameter int CLK_HZ    = `FLDC_CLK_HZ,
  parameter int MS_CYCLES = CLK_HZ / `FLDC_MS_PER_S
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [3:0]  RATE_BANK_LOW,
  input  wire logic [7:0]  RATE_BANK_HIGH,
  input  wire logic [3:0]  CLOCK_SOURCE_SWITCHES,
  input  wire logic [4:0]  CARRIER_DELAY_JUMPER,
  input  wire logic        DUPLEX_JUMPER,
  input  wire logic        RTS,
  input  wire logic        TD,
  input  wire logic        ETC,
  output logic             TC,
  output logic             RD,
  output logic             RC,
  output logic             CTS,
  output logic             DCD,
  output logic             DSR,
  input  wire logic        FIBER_RX_CLK,
  input  wire logic        FIBER_RX_DATA,
  input  wire logic        FIBER_RX_CARRIER,
  output logic             FIBER_TX_CLK,
  output logic             FIBER_TX_DATA,
  output logic             FIBER_TX_EN,
  output logic             LED_RTS,
  output logic             CARRIER_INDICATOR
);

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic logic [3:0] rate_decode(input logic [7:0] hi, input logic [3:0] lo);
    case ({hi, lo})
      `FLDC_SW_0: rate_decode = 4'h0;
      `FLDC_SW_1: rate_decode = 4'h1;
      `FLDC_SW_2: rate_decode = 4'h2;
      `FLDC_SW_3: rate_decode = 4'h3;
      `FLDC_SW_4: rate_decode = 4'h4;
      `FLDC_SW_5: rate_decode = 4'h5;
      `FLDC_SW_6: rate_decode = 4'h6;
      `FLDC_SW_7: rate_decode = 4'h7;
      `FLDC_SW_8: rate_decode = 4'h8;
      `FLDC_SW_9: rate_decode = 4'h9;
      default:    rate_decode = `FLDC_RATE_DEF;
    endcase
  endfunction : rate_decode

  function automatic logic [31:0] rate_bps(input logic [3:0] idx);
    case (idx)
      4'h0:    rate_bps = 32'(`FLDC_BPS_0);
      4'h1:    rate_bps = 32'(`FLDC_BPS_1);
      4'h2:    rate_bps = 32'(`FLDC_BPS_2);
      4'h3:    rate_bps = 32'(`FLDC_BPS_3);
      4'h4:    rate_bps = 32'(`FLDC_BPS_4);
      4'h5:    rate_bps = 32'(`FLDC_BPS_5);
      4'h6:    rate_bps = 32'(`FLDC_BPS_6);
      4'h7:    rate_bps = 32'(`FLDC_BPS_7);
      4'h8:    rate_bps = 32'(`FLDC_BPS_8);
      4'h9:    rate_bps = 32'(`FLDC_BPS_9);
      default: rate_bps = 32'(`FLDC_BPS_5);
    endcase
  endfunction : rate_bps

  function automatic logic [19:0] half_period(input logic [3:0] idx);
    case (idx)
      4'h0:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_0));
      4'h1:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_1));
      4'h2:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_2));
      4'h3:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_3));
      4'h4:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_4));
      4'h5:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_5));
      4'h6:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_6));
      4'h7:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_7));
      4'h8:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_8));
      4'h9:    half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_9));
      default: half_period = 20'(CLK_HZ / (2 * `FLDC_BPS_5));
    endcase
  endfunction : half_period

  function automatic fldc_src_e src_decode(input logic [3:0] sw);
    logic [2:0] sel;
    sel = {sw[`FLDC_CSW_EXT], sw[`FLDC_CSW_INT], sw[`FLDC_CSW_REC]};
    case (sel)
      3'h1:    src_decode = FLDC_SRC_REC;
      3'h4:    src_decode = FLDC_SRC_EXT;
      default: src_decode = FLDC_SRC_INT;
    endcase
  endfunction : src_decode

  function automatic fldc_car_e car_decode(input logic [4:0] j);
    if (j[`FLDC_JMP_E]) car_decode = FLDC_CAR_CONST;
    else if (j[`FLDC_JMP_D]) car_decode = FLDC_CAR_D;
    else if (j[`FLDC_JMP_C]) car_decode = FLDC_CAR_C;
    else if (j[`FLDC_JMP_B]) car_decode = FLDC_CAR_B;
    else if (j[`FLDC_JMP_A]) car_decode = FLDC_CAR_A;
    else car_decode = FLDC_CAR_CONST;
  endfunction : car_decode

  function automatic logic [7:0] car_delay(input fldc_car_e c);
    case (c)
      FLDC_CAR_D: car_delay = `FLDC_DLY_D_MS;
      FLDC_CAR_C: car_delay = `FLDC_DLY_C_MS;
      FLDC_CAR_B: car_delay = `FLDC_DLY_B_MS;
      FLDC_CAR_A: car_delay = `FLDC_DLY_A_MS;
      default:    car_delay = `FLDC_DLY_D_MS;
    endcase
  endfunction : car_delay

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  fldc_pins_s  pin_raw;
  fldc_pins_s  pin_meta_r;
  fldc_pins_s  pin_r;
  fldc_cfg_s   pin_cfg;
  fldc_cfg_s   reg_cfg;
  fldc_cfg_s   cfg_r;
  fldc_cts_e   cts_st_r;
  fldc_cts_e   cts_st_nxt;
  logic [31:0] ctrl_r;
  logic [31:0] rdata_r;
  logic        slverr_r;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [19:0] div_cnt_r;
  logic        int_tc_r;
  logic        tc_level;
  logic        tc_r;
  logic        tc_rise;
  logic        tx_data_r;
  logic        tx_en_r;
  logic        rx_clk_prev_r;
  logic        rd_r;
  logic        car_r;
  logic        dsr_r;
  logic        rts_prev_r;
  logic        rts_rise;
  logic        rts_eff;
  logic        cts_r;
  logic        led_rts_r;
  logic        timer_done;
  logic        constant;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign pin_raw = '{rate_lo: RATE_BANK_LOW, rate_hi: RATE_BANK_HIGH,
                     clk_sw: CLOCK_SOURCE_SWITCHES, jumper: CARRIER_DELAY_JUMPER,
                     half: DUPLEX_JUMPER, rts: RTS, td: TD, etc: ETC,
                     rx_clk: FIBER_RX_CLK, rx_data: FIBER_RX_DATA, rx_car: FIBER_RX_CARRIER};

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      pin_meta_r <= '0;
      pin_r      <= '0;
    end else begin
      pin_meta_r <= pin_raw;
      pin_r      <= pin_meta_r;
    end
  end

  // ----------------------------------------
  // Configuration: straps or register override
  // ----------------------------------------
  always_comb begin
    pin_cfg.rate = rate_decode(pin_r.rate_hi, pin_r.rate_lo);
    pin_cfg.src  = src_decode(pin_r.clk_sw);
    pin_cfg.car  = car_decode(pin_r.jumper);
    pin_cfg.half = pin_r.half;
  end

  always_comb begin
    reg_cfg.rate = (ctrl_r[`FLDC_CTRL_RATE +: 4] > 4'h9) ? `FLDC_RATE_DEF
                                                        : ctrl_r[`FLDC_CTRL_RATE +: 4];
    reg_cfg.src  = (ctrl_r[`FLDC_CTRL_SRC +: 2] == 2'h3) ? FLDC_SRC_INT
                                                        : fldc_src_e'(ctrl_r[`FLDC_CTRL_SRC +: 2]);
    reg_cfg.car  = (ctrl_r[`FLDC_CTRL_CAR +: 3] > 3'h4) ? FLDC_CAR_CONST
                                                       : fldc_car_e'(ctrl_r[`FLDC_CTRL_CAR +: 3]);
    reg_cfg.half = ctrl_r[`FLDC_CTRL_HALF];
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cfg_r <= '{rate: `FLDC_RATE_DEF, src: FLDC_SRC_INT, car: FLDC_CAR_CONST, half: 1'b0};
    end else begin
      cfg_r <= ctrl_r[`FLDC_CTRL_OVR] ? reg_cfg : pin_cfg;
    end
  end

  assign constant = (cfg_r.car == FLDC_CAR_CONST);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    case (PADDR)
      `FLDC_OFF_CTRL: rd_mux = ctrl_r;
      `FLDC_OFF_STAT: rd_mux = {18'h00000, tx_en_r, car_r, cts_r, led_rts_r,
                                cfg_r.half, cfg_r.car, cfg_r.src, cfg_r.rate};
      `FLDC_OFF_RATE: rd_mux = rate_bps(cfg_r.rate);
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rdata_r  <= 32'h00000000;
      slverr_r <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      rdata_r  <= PWRITE ? 32'h00000000 : rd_mux;
      slverr_r <= !rd_hit || (PWRITE && PADDR != `FLDC_OFF_CTRL);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ctrl_r <= `FLDC_CTRL_RST;
    end else if (PSEL && PENABLE && PWRITE && PADDR == `FLDC_OFF_CTRL) begin
      ctrl_r <= PWDATA & 32'h0001_7FF1;
    end
  end

  assign PREADY  = 1'b1;
  assign PRDATA  = rdata_r;
  assign PSLVERR = PSEL && PENABLE && slverr_r;

  // ----------------------------------------
  // Internal transmit clock generator
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      div_cnt_r <= 20'h00000;
      int_tc_r  <= 1'b0;
    end else if (div_cnt_r >= half_period(cfg_r.rate) - 20'h00001) begin
      div_cnt_r <= 20'h00000;
      int_tc_r  <= !int_tc_r;
    end else begin
      div_cnt_r <= div_cnt_r + 20'h00001;
    end
  end

  // ----------------------------------------
  // Transmit clock selection and data path
  // ----------------------------------------
  always_comb begin
    case (cfg_r.src)
      FLDC_SRC_INT: tc_level = int_tc_r;
      FLDC_SRC_REC: tc_level = pin_r.rx_clk;
      FLDC_SRC_EXT: tc_level = pin_r.etc;
      default:      tc_level = int_tc_r;
    endcase
  end

  assign tc_rise = tc_level && !tc_r;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      tc_r      <= 1'b0;
      tx_data_r <= 1'b0;
    end else begin
      tc_r <= tc_level;
      if (tc_rise) begin
        tx_data_r <= tx_en_r ? pin_r.td : 1'b0;
      end
    end
  end

  assign TC            = tc_r;
  assign FIBER_TX_CLK  = tc_r;
  assign FIBER_TX_DATA = tx_data_r;

  // ----------------------------------------
  // Receive path and carrier detect
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rx_clk_prev_r <= 1'b0;
      rd_r          <= 1'b1;
      car_r         <= 1'b0;
      dsr_r         <= 1'b0;
    end else begin
      rx_clk_prev_r <= pin_r.rx_clk;
      if (pin_r.rx_clk && !rx_clk_prev_r) begin
        rd_r <= pin_r.rx_data;
      end
      car_r <= pin_r.rx_car;
      dsr_r <= 1'b1;
    end
  end

  assign RD                = rd_r;
  assign RC                = rx_clk_prev_r;
  assign DCD               = car_r;
  assign CARRIER_INDICATOR = car_r;
  assign DSR               = dsr_r;

  // ----------------------------------------
  // RTS/CTS handshake
  // ----------------------------------------
  assign rts_rise = pin_r.rts && !rts_prev_r;
  assign rts_eff  = constant || pin_r.rts;

  fldc_delay_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk      (CLOCK),
    .resetn   (RESETN),
    .restart  (rts_rise),
    .delay_ms (car_delay(cfg_r.car)),
    .done     (timer_done)
  );

  always_comb begin
    cts_st_nxt = cts_st_r;
    case (cts_st_r)
      FLDC_CTS_IDLE: begin
        if (constant) cts_st_nxt = FLDC_CTS_CLEAR;
        else if (rts_rise) cts_st_nxt = FLDC_CTS_WAIT;
      end
      FLDC_CTS_WAIT: begin
        if (!rts_eff) cts_st_nxt = FLDC_CTS_IDLE;
        else if (rts_rise) cts_st_nxt = FLDC_CTS_WAIT;
        else if (constant) cts_st_nxt = FLDC_CTS_CLEAR;
        else if (timer_done && !(cfg_r.half && car_r)) cts_st_nxt = FLDC_CTS_CLEAR;
      end
      FLDC_CTS_CLEAR: begin
        if (!rts_eff) cts_st_nxt = FLDC_CTS_IDLE;
        else if (rts_rise && !constant) cts_st_nxt = FLDC_CTS_WAIT;
      end
      default: cts_st_nxt = FLDC_CTS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cts_st_r   <= FLDC_CTS_IDLE;
      rts_prev_r <= 1'b0;
    end else begin
      cts_st_r   <= cts_st_nxt;
      rts_prev_r <= pin_r.rts;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cts_r     <= 1'b0;
      tx_en_r   <= 1'b0;
      led_rts_r <= 1'b0;
    end else begin
      cts_r     <= (cts_st_nxt == FLDC_CTS_CLEAR);
      tx_en_r   <= rts_eff;
      led_rts_r <= rts_eff;
    end
  end

  // Transmitter enable lights the remote carrier indicator
  assign FIBER_TX_EN = tx_en_r;
  assign LED_RTS     = led_rts_r;
  assign CTS         = cts_r;

endmodule : fldc_top

// ---- tb/fldc_top_properties.sv ----
`timescale 1ns/1ps
`include "fldc_params.svh"

module fldc_top_properties #(
  parameter int MS_CYCLES = 50000
) (
  input wire logic       CLOCK,
  input wire logic       RESETN,
  input wire logic [3:0] CLOCK_SOURCE_SWITCHES,
  input wire logic [4:0] CARRIER_DELAY_JUMPER,
  input wire logic       DUPLEX_JUMPER,
  input wire logic       RTS,
  input wire logic       TD,
  input wire logic       ETC,
  input wire logic       TC,
  input wire logic       RD,
  input wire logic       RC,
  input wire logic       CTS,
  input wire logic       DCD,
  input wire logic       FIBER_RX_CLK,
  input wire logic       FIBER_RX_DATA,
  input wire logic       FIBER_RX_CARRIER,
  input wire logic       FIBER_TX_CLK,
  input wire logic       FIBER_TX_DATA,
  input wire logic       FIBER_TX_EN,
  input wire logic       LED_RTS,
  input wire logic       CARRIER_INDICATOR
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic        sw_mode;
  logic        ext_sel;
  logic        rec_sel;
  logic [7:0]  dly_ms;
  int          lim;
  logic [15:0] rts_cnt_r;

  assign sw_mode = !CARRIER_DELAY_JUMPER[4] && (CARRIER_DELAY_JUMPER[3:0] != 4'h0);
  assign ext_sel = CLOCK_SOURCE_SWITCHES[2:0] == 3'h4;
  assign rec_sel = CLOCK_SOURCE_SWITCHES[2:0] == 3'h1;
  assign dly_ms  = CARRIER_DELAY_JUMPER[3] ? `FLDC_DLY_D_MS : CARRIER_DELAY_JUMPER[2] ? `FLDC_DLY_C_MS :
                   CARRIER_DELAY_JUMPER[1] ? `FLDC_DLY_B_MS : `FLDC_DLY_A_MS;
  assign lim     = int'(dly_ms) * MS_CYCLES;

  always_ff @(posedge CLOCK) begin
    if (!RESETN || !RTS) begin
      rts_cnt_r <= 16'h0000;
    end else if (rts_cnt_r != 16'hFFFF) begin
      rts_cnt_r <= rts_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  sequence s_ext_held; ext_sel [*6]; endsequence
  sequence s_rec_held; rec_sel [*6]; endsequence

  property p_const; CARRIER_DELAY_JUMPER[4] [*8] |-> CTS && FIBER_TX_EN && LED_RTS; endproperty
  property p_sw_on; (sw_mode && RTS) [*5] |-> LED_RTS && FIBER_TX_EN; endproperty
  property p_sw_off; (sw_mode && !RTS) [*8] |-> !LED_RTS && !FIBER_TX_EN && !CTS; endproperty
  property p_cts_early; sw_mode && $rose(CTS) |-> rts_cnt_r >= lim && rts_cnt_r <= lim + 8; endproperty
  property p_cts_due; sw_mode && !DUPLEX_JUMPER && rts_cnt_r == lim + 10 |-> CTS; endproperty
  property p_cd_on; $rose(FIBER_RX_CARRIER) |-> ##[2:4] CARRIER_INDICATOR && DCD; endproperty
  property p_cd_off; $fell(FIBER_RX_CARRIER) |-> ##[2:4] !CARRIER_INDICATOR; endproperty
  property p_ext_tc; s_ext_held ##0 $rose(ETC) |-> ##[2:5] $rose(TC); endproperty
  property p_rec_tc; s_rec_held ##0 $rose(FIBER_RX_CLK) |-> ##[2:5] $rose(TC); endproperty
  property p_tx_data; $past(FIBER_TX_EN) && $rose(FIBER_TX_CLK) |-> FIBER_TX_DATA == $past(TD, 3); endproperty
  property p_rx_data; $rose(RC) |-> RD == $past(FIBER_RX_DATA, 3); endproperty

  a_const: assert property (p_const) else $error("constant carrier outputs low");
  a_sw_on: assert property (p_sw_on) else $error("request not shown");
  a_sw_off: assert property (p_sw_off) else $error("outputs active without request");
  a_cts_early: assert property (p_cts_early) else $error("clear to send off time");
  a_cts_due: assert property (p_cts_due) else $error("clear to send missing");
  a_cd_on: assert property (p_cd_on) else $error("carrier indicator not lit");
  a_cd_off: assert property (p_cd_off) else $error("carrier indicator stuck");
  a_ext_tc: assert property (p_ext_tc) else $error("external clock not returned");
  a_rec_tc: assert property (p_rec_tc) else $error("recovered clock not used");
  a_tx_data: assert property (p_tx_data) else $error("transmit data not forwarded");
  a_rx_data: assert property (p_rx_data) else $error("receive data not passed");
endmodule : fldc_top_properties

bind fldc_top fldc_top_properties #(.MS_CYCLES(MS_CYCLES)) u_fldc_top_properties (
  .CLOCK(CLOCK), .RESETN(RESETN), .CLOCK_SOURCE_SWITCHES(CLOCK_SOURCE_SWITCHES),
  .TD(TD), .RD(RD), .RC(RC), .FIBER_RX_DATA(FIBER_RX_DATA), .FIBER_TX_CLK(FIBER_TX_CLK),
  .FIBER_TX_DATA(FIBER_TX_DATA),
  .CARRIER_DELAY_JUMPER(CARRIER_DELAY_JUMPER), .DUPLEX_JUMPER(DUPLEX_JUMPER), .RTS(RTS), .ETC(ETC),
  .TC(TC), .CTS(CTS), .DCD(DCD), .FIBER_RX_CLK(FIBER_RX_CLK), .FIBER_RX_CARRIER(FIBER_RX_CARRIER),
  .FIBER_TX_EN(FIBER_TX_EN), .LED_RTS(LED_RTS), .CARRIER_INDICATOR(CARRIER_INDICATOR)
);

// ---- tb/fldc_dte_model.sv ----
`timescale 1ns/1ps

module fldc_dte_model (
  input  wire logic clk,
  input  wire logic req,
  input  wire logic ext_on,
  input  wire logic cts,
  input  wire logic tc,
  output logic      rts,
  output logic      td,
  output logic      etc
);
  logic       tc_d = 1'b0;
  logic [7:0] pat  = 8'hB4;
  logic [1:0] ph   = 2'h0;

  // ----------------------------------------
  // Request and data
  // ----------------------------------------
  always @(posedge clk) begin
    rts  <= req;
    tc_d <= tc;
    ph   <= ph + 2'h1;
    if (ph == 2'h3) begin
      etc <= ext_on && !etc;
    end
    if ((tc_d && !tc) || !cts) begin
      td  <= cts ? pat[0] : 1'b1;
      pat <= cts ? {pat[0], pat[7:1]} : pat;
    end
  end
endmodule : fldc_dte_model

// ---- tb/fldc_top_tb_top.sv ----
`timescale 1ns/1ps
`include "fldc_params.svh"

module fldc_top_tb_top;
  localparam int MS   = 20;
  localparam int HALF = `FLDC_CLK_HZ / (2 * `FLDC_BPS_5);

  logic        clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, tc, rd_o, rc, cts, dcd, dsr, ftc, ftd, ften, led, cind, rts, td, etc;
  logic [3:0]  rlo = 4'h0, csw = 4'hA;
  logic [7:0]  rhi = 8'hF5;
  logic [4:0]  jmp = 5'h10;
  logic        dup = 1'b0, req = 1'b0, ext_on = 1'b0, lk_on = 1'b0, rxc = 1'b0, rxd = 1'b0, rxcar = 1'b0;
  int          errors = 0, compares = 0;

  fldc_top #(.MS_CYCLES(MS)) u_fldc_top (
    .CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RATE_BANK_LOW(rlo),
    .RATE_BANK_HIGH(rhi), .CLOCK_SOURCE_SWITCHES(csw), .CARRIER_DELAY_JUMPER(jmp), .DUPLEX_JUMPER(dup),
    .RTS(rts), .TD(td), .ETC(etc), .TC(tc), .RD(rd_o), .RC(rc), .CTS(cts), .DCD(dcd), .DSR(dsr),
    .FIBER_RX_CLK(rxc), .FIBER_RX_DATA(rxd), .FIBER_RX_CARRIER(rxcar), .FIBER_TX_CLK(ftc),
    .FIBER_TX_DATA(ftd), .FIBER_TX_EN(ften), .LED_RTS(led), .CARRIER_INDICATOR(cind)
  );

  fldc_dte_model u_fldc_dte_model (
    .clk(clock), .req(req), .ext_on(ext_on), .cts(cts), .tc(tc), .rts(rts), .td(td), .etc(etc)
  );

  // ----------------------------------------
  // Clocks
  // ----------------------------------------
  initial begin
    forever #10 clock = ~clock;
  end

  logic [1:0] lk_ph = 2'h0;

  always @(posedge clock) begin
    lk_ph <= lk_ph + 2'h1;
    if (lk_ph == 2'h3) rxc <= lk_on && !rxc;
  end

  always @(posedge rxc) rxd <= ~rxd;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic in_range(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, v, lo, hi);
    end
  endtask : in_range

  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] exp, input logic eexp);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    if (!w) chk(prdata & m, exp);
    chk({31'h0, pslverr}, {31'h0, eexp});
    psel <= 1'b0; penable <= 1'b0;
  endtask : acc

  task automatic hi_len(output int n);
    int g;
    g = 0;
    while (tc !== 1'b0 && g < 3000) begin @(posedge clock); g++; end
    while (tc !== 1'b1 && g < 3000) begin @(posedge clock); g++; end
    n = 0;
    while (tc === 1'b1 && n < 3000) begin @(posedge clock); n++; end
  endtask : hi_len

  task automatic rts_up(output int n);
    req <= 1'b1;
    n = 0;
    while (cts !== 1'b1 && n < 5000) begin @(posedge clock); n++; end
  endtask : rts_up

  task automatic finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    errors++;
    finish_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int          n;
    int          bps [10];
    logic [11:0] sw [10];
    int          dl [4];
    bps = '{`FLDC_BPS_0, `FLDC_BPS_1, `FLDC_BPS_2, `FLDC_BPS_3, `FLDC_BPS_4,
            `FLDC_BPS_5, `FLDC_BPS_6, `FLDC_BPS_7, `FLDC_BPS_8, `FLDC_BPS_9};
    sw  = '{`FLDC_SW_0, `FLDC_SW_1, `FLDC_SW_2, `FLDC_SW_3, `FLDC_SW_4,
            `FLDC_SW_5, `FLDC_SW_6, `FLDC_SW_7, `FLDC_SW_8, `FLDC_SW_9};
    dl  = '{`FLDC_DLY_A_MS, `FLDC_DLY_B_MS, `FLDC_DLY_C_MS, `FLDC_DLY_D_MS};
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (10) @(posedge clock);
    acc(1'b0, `FLDC_OFF_RATE, 32'h0, 32'hFFFFFFFF, `FLDC_BPS_5, 1'b0);
    acc(1'b0, `FLDC_OFF_STAT, 32'h0, 32'h00003FFF, 32'h00002C05, 1'b0);
    acc(1'b0, `FLDC_OFF_CTRL, 32'h0, 32'hFFFFFFFF, `FLDC_CTRL_RST, 1'b0);
    acc(1'b1, `FLDC_OFF_CTRL, 32'hFFFFFFFE, 32'h0, 32'h0, 1'b0);
    acc(1'b0, `FLDC_OFF_CTRL, 32'h0, 32'hFFFFFFFF, 32'h00017FF0, 1'b0);
    acc(1'b1, `FLDC_OFF_CTRL, 32'h00000091, 32'h0, 32'h0, 1'b0);
    acc(1'b0, `FLDC_OFF_RATE, 32'h0, 32'hFFFFFFFF, `FLDC_BPS_9, 1'b0);
    acc(1'b1, `FLDC_OFF_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 12'h00C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    acc(1'b1, `FLDC_OFF_STAT, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b1);
    acc(1'b0, `FLDC_OFF_STAT, 32'h0, 32'h000003FF, 32'h00000005, 1'b0);
    for (int i = 0; i < 10; i++) begin
      {rhi, rlo} <= sw[i];
      repeat (6) @(posedge clock);
      acc(1'b0, `FLDC_OFF_RATE, 32'h0, 32'hFFFFFFFF, bps[i], 1'b0);
    end
    {rhi, rlo} <= `FLDC_SW_5;
    repeat (6) @(posedge clock);
    hi_len(n);
    in_range(n, HALF - 1, HALF + 1);
    csw <= 4'h9;
    lk_on <= 1'b1;
    repeat (8) @(posedge clock);
    acc(1'b0, `FLDC_OFF_STAT, 32'h0, 32'h00000030, 32'h00000010, 1'b0);
    hi_len(n);
    in_range(n, 3, 5);
    lk_on <= 1'b0;
    csw <= 4'hC;
    ext_on <= 1'b1;
    repeat (8) @(posedge clock);
    acc(1'b0, `FLDC_OFF_STAT, 32'h0, 32'h00000030, 32'h00000020, 1'b0);
    hi_len(n);
    in_range(n, 3, 5);
    ext_on <= 1'b0;
    csw <= 4'hA;
    rxcar <= 1'b1;
    repeat (6) @(posedge clock);
    chk({31'h0, cind}, 32'h1);
    chk({31'h0, dsr}, 32'h1);
    acc(1'b0, `FLDC_OFF_STAT, 32'h0, 32'h00001030, 32'h00001000, 1'b0);
    rxcar <= 1'b0;
    for (int k = 3; k >= 0; k--) begin
      jmp <= 5'h01 << k;
      repeat (10) @(posedge clock);
      rts_up(n);
      in_range(n, dl[k] * MS, dl[k] * MS + 12);
      repeat (20) @(posedge clock);
      acc(1'b0, `FLDC_OFF_STAT, 32'h0, 32'h00002C00, 32'h00002C00, 1'b0);
      req <= 1'b0;
      repeat (8) @(posedge clock);
      acc(1'b0, `FLDC_OFF_STAT, 32'h0, 32'h00002C00, 32'h0, 1'b0);
    end
    jmp <= 5'h04;
    repeat (10) @(posedge clock);
    req <= 1'b1;
    repeat (100) @(posedge clock);
    req <= 1'b0;
    repeat (10) @(posedge clock);
    rts_up(n);
    in_range(n, dl[2] * MS, dl[2] * MS + 12);
    req <= 1'b0;
    dup <= 1'b1;
    repeat (6) @(posedge clock);
    acc(1'b0, `FLDC_OFF_STAT, 32'h0, 32'h00000200, 32'h00000200, 1'b0);
    rxcar <= 1'b1;
    req   <= 1'b1;
    repeat (300) @(posedge clock);
    chk({31'h0, cts}, 32'h0);
    req   <= 1'b0;
    rxcar <= 1'b0;
    dup <= 1'b0;
    repeat (4) @(posedge clock);
    finish_test();
  end
endmodule : fldc_top_tb_top
